// ==== src/ucd_pkg.sv ====
// constants and types of the uart command decoder
// assumes one clock domain shared with the rest of the uart channel
// Summary of operation
// - bits 6..4 pick one miscellaneous command; 000 does nothing
// - code 001 points the mode pointer back at the first mode register
// - code 010 stops receiver unless loopback or multidrop, clears full/ready flags, reinitializes fifo pointer
// - code 011 disables transmitter and clears empty and ready flags
// - code 100 clears break, framing, parity and overrun error flags
// - code 101 clears the delta-break flag
// - code 110 forces line low; idle start may lag one bit time
// - break waits for shifting character; held character goes after the break
// - start break is accepted only while transmitter is enabled
// - start break ignores clear-to-send
// - code 111 returns line to mark within two bit times, then sends
// - bits 3..2 are transmit command; 00 keeps transmitter state
// - transmit 01 enables and sets empty and ready flags; no-op if enabled
// - transmit 10 disables after current character, clears flags; no-op if off
// - bits 1..0 are receive command; 00 keeps receiver state
// - receive 01 enables and hunts start bit unless multidrop; no-op if on
// - receive 10 disables now, drops character; loopback or multidrop keeps running
package ucd_pkg;

  localparam int unsigned ADDR_W = 4;
  localparam logic [3:0] OFS_COMMAND = 4'h0;
  localparam logic [3:0] OFS_STATE = 4'h4;

  localparam int unsigned MISC_LSB = 4;
  localparam int unsigned TXC_LSB = 2;
  localparam int unsigned RXC_LSB = 0;

  localparam logic [2:0] MISC_NONE = 3'h0;
  localparam logic [2:0] MISC_MODE_PTR = 3'h1;
  localparam logic [2:0] MISC_RX_RESET = 3'h2;
  localparam logic [2:0] MISC_TX_RESET = 3'h3;
  localparam logic [2:0] MISC_ERR_RESET = 3'h4;
  localparam logic [2:0] MISC_DB_RESET = 3'h5;
  localparam logic [2:0] MISC_BRK_START = 3'h6;
  localparam logic [2:0] MISC_BRK_STOP = 3'h7;

  localparam logic [1:0] DIR_NONE = 2'h0;
  localparam logic [1:0] DIR_ENABLE = 2'h1;
  localparam logic [1:0] DIR_DISABLE = 2'h2;

  localparam logic RST_EN = 1'h0;

  typedef enum logic [1:0] {
    BRK_IDLE,
    BRK_WAIT,
    BRK_LOW,
    BRK_STOP
  } ucd_brk_t;

  // receive status flags: break, framing, parity, overrun
  typedef struct packed {
    logic oe;
    logic pe;
    logic fe;
    logic rb;
  } ucd_err_t;

  // one-cycle strobes towards the rest of the channel
  typedef struct packed {
    logic mode_ptr_rst;
    logic rx_reset;
    logic rx_hunt;
    logic rx_abort;
    logic tx_flags_set;
    logic tx_flags_clr;
  } ucd_evt_t;

  typedef struct packed {
    logic tx_en;
    logic tx_drain;
    logic rx_en;
    ucd_brk_t brk;
    ucd_err_t err;
    logic db;
    ucd_evt_t evt;
    logic [7:0] rdata;
  } ucd_state_t;

endpackage : ucd_pkg

// ==== src/ucd_decoder.sv ====
// command decoder of one uart channel with its control and error flags
// assumes bit_tick is a one-cycle enable per bit time from the baud divider,
// and all status inputs come from logic on clk
//
// The plain strobed port and the register offsets are this design's own decisions.
`timescale 1ns/10ps

module ucd_decoder (
  input wire logic clk,
  input wire logic resetn,
  // register port
  input wire logic [ucd_pkg::ADDR_W-1:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [7:0] rdata,
  // channel side
  input wire logic bit_tick,
  input wire logic tx_shifting,
  input wire logic multidrop,
  input wire logic loopback,
  input wire ucd_pkg::ucd_err_t err_set,
  input wire logic db_set,
  output ucd_pkg::ucd_evt_t evt,
  output logic tx_active,
  output logic tx_hold_off,
  output logic txd_force_low,
  output logic rx_active
);

  // ******************************************************************
  // field decode
  // ******************************************************************

  ucd_pkg::ucd_state_t s_q;
  ucd_pkg::ucd_state_t s_d;

  logic cmd_wr;
  logic [2:0] misc;
  logic [1:0] txc;
  logic [1:0] rxc;

  function automatic logic [1:0] dir_field(
    input logic [7:0] v,
    input int unsigned lsb
  );
    dir_field = 2'((v >> lsb) & 8'h03);
  endfunction

  function automatic logic is_cmd(
    input logic [2:0] m,
    input logic [2:0] code
  );
    is_cmd = (m == code);
  endfunction

  // bit 7 is ignored on purpose
  assign cmd_wr = wr && (addr == ucd_pkg::OFS_COMMAND);
  assign misc = cmd_wr ? 3'((wdata >> ucd_pkg::MISC_LSB) & 8'h07)
                       : ucd_pkg::MISC_NONE;
  assign txc = cmd_wr ? dir_field(wdata, ucd_pkg::TXC_LSB)
                      : ucd_pkg::DIR_NONE;
  assign rxc = cmd_wr ? dir_field(wdata, ucd_pkg::RXC_LSB)
                      : ucd_pkg::DIR_NONE;

  // ******************************************************************
  // next state
  // ******************************************************************

  always_comb begin
    s_d = s_q;
    s_d.evt = '0;
    s_d.rdata = 8'h00;

    // miscellaneous field, one command per write
    if (is_cmd(misc, ucd_pkg::MISC_MODE_PTR)) begin
      s_d.evt.mode_ptr_rst = 1'b1;
    end

    if (is_cmd(misc, ucd_pkg::MISC_RX_RESET)) begin
      s_d.rx_en = 1'b0;
      s_d.evt.rx_reset = 1'b1;
      s_d.evt.rx_abort = 1'b1;
    end

    if (is_cmd(misc, ucd_pkg::MISC_TX_RESET)) begin
      s_d.tx_en = 1'b0;
      s_d.tx_drain = 1'b0;
      s_d.brk = ucd_pkg::BRK_IDLE;
      s_d.evt.tx_flags_clr = 1'b1;
    end

    // error flags: a set in the clearing cycle wins
    if (is_cmd(misc, ucd_pkg::MISC_ERR_RESET)) begin
      s_d.err = '0;
    end
    s_d.err = s_d.err | err_set;

    if (is_cmd(misc, ucd_pkg::MISC_DB_RESET)) begin
      s_d.db = 1'b0;
    end
    s_d.db = s_d.db | db_set;

    // transmit field, independent of the miscellaneous field
    case (txc)
      ucd_pkg::DIR_ENABLE: begin
        if (!s_q.tx_en) begin
          s_d.tx_en = 1'b1;
          s_d.tx_drain = 1'b0;
          s_d.evt.tx_flags_set = 1'b1;
        end
      end
      ucd_pkg::DIR_DISABLE: begin
        if (s_q.tx_en) begin
          s_d.tx_en = 1'b0;
          s_d.tx_drain = tx_shifting;
          s_d.evt.tx_flags_clr = 1'b1;
        end
      end
      default: begin
        s_d.tx_en = s_d.tx_en;
      end
    endcase

    // a disabled transmitter stays active until its character is out
    if (s_q.tx_drain && !tx_shifting) begin
      s_d.tx_drain = 1'b0;
    end

    // receive field
    case (rxc)
      ucd_pkg::DIR_ENABLE: begin
        if (!s_q.rx_en && !multidrop) begin
          s_d.rx_en = 1'b1;
          s_d.evt.rx_hunt = 1'b1;
        end
      end
      ucd_pkg::DIR_DISABLE: begin
        if (s_q.rx_en) begin
          s_d.rx_en = 1'b0;
          s_d.evt.rx_abort = 1'b1;
        end
      end
      default: begin
        s_d.rx_en = s_d.rx_en;
      end
    endcase

    // ****************************************************************
    // break sequencer
    // ****************************************************************

    case (s_q.brk)
      ucd_pkg::BRK_IDLE: begin
        // no clear-to-send term here on purpose
        if (is_cmd(misc, ucd_pkg::MISC_BRK_START) && s_q.tx_en) begin
          s_d.brk = ucd_pkg::BRK_WAIT;
        end
      end
      ucd_pkg::BRK_WAIT: begin
        if (is_cmd(misc, ucd_pkg::MISC_BRK_STOP)) begin
          s_d.brk = ucd_pkg::BRK_IDLE;
        end else if (!tx_shifting && bit_tick) begin
          s_d.brk = ucd_pkg::BRK_LOW;
        end
      end
      ucd_pkg::BRK_LOW: begin
        if (is_cmd(misc, ucd_pkg::MISC_BRK_STOP)) begin
          s_d.brk = ucd_pkg::BRK_STOP;
        end
      end
      ucd_pkg::BRK_STOP: begin
        // line returns to mark on the next bit boundary
        if (bit_tick) begin
          s_d.brk = ucd_pkg::BRK_IDLE;
        end
      end
      default: begin
        s_d.brk = ucd_pkg::BRK_IDLE;
      end
    endcase

    if (is_cmd(misc, ucd_pkg::MISC_TX_RESET)) begin
      s_d.brk = ucd_pkg::BRK_IDLE;
    end

    // ****************************************************************
    // read data, valid the cycle after the strobe
    // ****************************************************************

    if (rd && (addr == ucd_pkg::OFS_STATE)) begin
      s_d.rdata = {s_q.brk != ucd_pkg::BRK_IDLE,
                   s_q.tx_en,
                   s_q.rx_en,
                   s_q.db,
                   s_q.err};
    end
  end

  // ******************************************************************
  // state register
  // ******************************************************************

  always_ff @(posedge clk or negedge resetn) begin
    if (resetn == ucd_pkg::RST_EN) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // ******************************************************************
  // outputs
  // ******************************************************************

  assign rdata = s_q.rdata;
  assign evt = s_q.evt;
  assign tx_active = s_q.tx_en | s_q.tx_drain;
  // the shifter loads no held character until the break is over
  assign tx_hold_off = (s_q.brk != ucd_pkg::BRK_IDLE);
  assign txd_force_low = (s_q.brk == ucd_pkg::BRK_LOW)
                       | (s_q.brk == ucd_pkg::BRK_STOP);
  assign rx_active = s_q.rx_en | loopback | multidrop;

endmodule // ucd_decoder

// ==== testbench/ucd_decoder_assertions.sv ====
// port checker of the uart command decoder
// assumes bit_tick pulses once every 8 clocks
`timescale 1ns/10ps

module ucd_checker (
  input wire logic clk,
  input wire logic resetn,
  input wire logic [ucd_pkg::ADDR_W-1:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic bit_tick,
  input wire logic tx_shifting,
  input wire logic multidrop,
  input wire logic loopback,
  input wire ucd_pkg::ucd_evt_t evt,
  input wire logic tx_active,
  input wire logic txd_force_low,
  input wire logic rx_active
);
  localparam int MARK_MAX = 16;
  logic c;
  logic lm;
  logic [2:0] m;
  assign c = wr && addr == ucd_pkg::OFS_COMMAND;
  assign lm = !loopback && !multidrop;
  assign m = wdata[6:4];
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  // ****************
  // port relations
  // ****************
  property p_mode; c && m == 3'h1 |=> evt.mode_ptr_rst; endproperty
  a_mode: assert property (p_mode) else $error("mode pointer kept");
  property p_rxrst; c && m == 3'h2 && lm |=> evt.rx_reset && !rx_active; endproperty
  a_rxrst: assert property (p_rxrst) else $error("receiver reset");
  property p_txrst; c && m == 3'h3 |=> evt.tx_flags_clr && !tx_active; endproperty
  a_txrst: assert property (p_txrst) else $error("transmitter reset");
  property p_drain; c && wdata[3:2] == 2'h2 && tx_active && tx_shifting |=> tx_active;
  endproperty
  a_drain: assert property (p_drain) else $error("character cut short");
  property p_txen; c && wdata[3:2] == 2'h1 |=> tx_active && !evt.tx_flags_clr; endproperty
  a_txen: assert property (p_txen) else $error("transmit enable");
  property p_rxen; c && wdata[1:0] == 2'h1 && m != 3'h2 && !multidrop |=> rx_active;
  endproperty
  a_rxen: assert property (p_rxen) else $error("receive enable");
  property p_rxoff; (c && wdata[1:0] == 2'h2 && lm) ##1 lm |-> !rx_active; endproperty
  a_rxoff: assert property (p_rxoff) else $error("receive disable");
  property p_loop; loopback || multidrop |-> rx_active; endproperty
  a_loop: assert property (p_loop) else $error("receiver stopped");
  property p_brk; $rose(txd_force_low) |-> $past(bit_tick) && !$past(tx_shifting); endproperty
  a_brk: assert property (p_brk) else $error("break started early");
  property p_mark; c && m == 3'h7 && txd_force_low |-> ##[1:MARK_MAX] !txd_force_low;
  endproperty
  a_mark: assert property (p_mark) else $error("break not released");
  c_brk: cover property (c && m == 3'h6 && tx_active);
  c_low: cover property ($rose(txd_force_low));
  c_both: cover property (c && wdata[3:0] == 4'h5);
endmodule // ucd_checker

// ==== testbench/ucd_decoder_bench.sv ====
// self-checking bench of the uart command decoder
// assumes the checker file is compiled before this one
`timescale 1ns/10ps

module ucd_decoder_bench;
  logic clk = 0, resetn = 0, wr = 0, rd = 0, bit_tick = 0, tx_shifting = 0;
  logic multidrop = 0, loopback = 0, db_set = 0;
  logic [3:0] addr = 4'h0;
  logic [7:0] wdata = 8'h00, rdata;
  ucd_pkg::ucd_err_t err_set = '0;
  ucd_pkg::ucd_evt_t evt;
  logic tx_active, tx_hold_off, txd_force_low, rx_active;
  logic tx_en = 0, rx_en = 0, db = 0;
  logic [3:0] err = 4'h0;
  logic [31:0] seed = 32'h0000_72ED;
  logic [7:0] hv[4] = '{8'h05, 8'h05, 8'h0A, 8'h0A};
  int num_errors = 0, n_checks = 0, cnt = 0;
  ucd_decoder i_dut (.*);
  initial begin
    forever #25 clk = ~clk;
  end
  always @(posedge clk) begin
    cnt <= cnt + 1;
    bit_tick <= cnt % 8 == 7;
  end
  // ****************
  // helpers
  // ****************
  function automatic logic [31:0] xs(logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    return s ^ (s << 5);
  endfunction
  function automatic logic [5:0] exp_evt(logic [7:0] v);
    return {v[6:4] == 3'h1, v[6:4] == 3'h2, v[1:0] == 2'h1 && !rx_en && !multidrop,
      v[6:4] == 3'h2 || (v[1:0] == 2'h2 && rx_en), v[3:2] == 2'h1 && !tx_en,
      v[6:4] == 3'h3 || (v[3:2] == 2'h2 && tx_en)};
  endfunction
  task automatic chk(string what, logic [7:0] exp, logic [7:0] got);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("FAIL %s exp %h got %h", what, exp, got);
    end
  endtask
  task automatic put(logic [3:0] a, logic [7:0] v, logic [4:0] s);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= v;
    {db_set, err_set} <= s;
    @(posedge clk);
    wr <= 1'b0;
    {db_set, err_set} <= 5'h00;
  endtask
  task automatic step(logic [3:0] a, logic [7:0] v, logic [4:0] s);
    logic [5:0] e;
    e = a == 4'h0 ? exp_evt(v) : 6'h00;
    put(a, v, s);
    rd <= 1'b1;
    addr <= 4'h4;
    #1 chk("evt", {2'h0, e}, {2'h0, evt});
    if (a == 4'h0) begin
      tx_en = (tx_en || v[3:2] == 2'h1) && v[3:2] != 2'h2 && v[6:4] != 3'h3;
      rx_en = (rx_en || (v[1:0] == 2'h1 && !multidrop)) && v[1:0] != 2'h2 && v[6:4] != 3'h2;
      err = v[6:4] == 3'h4 ? 4'h0 : err;
      db = db && v[6:4] != 3'h5;
    end
    err = err | s[3:0];
    db = db | s[4];
    @(posedge clk);
    rd <= 1'b0;
    #1 chk("state", {1'b0, tx_en, rx_en, db, err}, rdata);
  endtask
  task automatic close_out;
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  initial begin
    #200us;
    num_errors++;
    close_out;
  end
  // ****************
  // scenarios
  // ****************
  initial begin
    logic [7:0] v;
    repeat (16) @(posedge clk);
    resetn <= 1'b1;
    foreach (hv[i]) step(4'h0, hv[i], 5'h00);
    step(4'h0, 8'h20, 5'h00);
    step(4'h0, 8'h30, 5'h00);
    @(posedge clk) multidrop <= 1'b1;
    #1 step(4'h0, 8'h01, 5'h00);
    @(posedge clk) multidrop <= 1'b0;
    repeat (60) begin
      seed = xs(seed);
      v = {1'b0, seed[6:0]};
      if (v[6:5] == 2'b11) v[5] = 1'b0;
      if (v[3:2] == 2'b11 || v[6:4] == 3'h3) v[3:2] = 2'b00;
      if (v[1:0] == 2'b11 || v[6:4] == 3'h2) v[1:0] = 2'b00;
      step(seed[15:14] == 2'b00 ? 4'h8 : 4'h0, v, seed[20:16] & {5{seed[21]}});
    end
    put(4'h0, 8'h04, 5'h00);
    @(posedge clk) tx_shifting <= 1'b1;
    put(4'h0, 8'h60, 5'h00);
    repeat (20) @(posedge clk);
    #1 chk("low", 8'h00, {7'h0, txd_force_low});
    chk("hold", 8'h01, {7'h0, tx_hold_off});
    @(posedge clk) tx_shifting <= 1'b0;
    repeat (10) @(posedge clk);
    #1 chk("low", 8'h01, {7'h0, txd_force_low});
    put(4'h0, 8'h70, 5'h00);
    repeat (17) @(posedge clk);
    #1 chk("low", 8'h00, {7'h0, txd_force_low});
    chk("hold", 8'h00, {7'h0, tx_hold_off});
    @(posedge clk) tx_shifting <= 1'b1;
    put(4'h0, 8'h08, 5'h00);
    repeat (5) @(posedge clk);
    #1 chk("active", 8'h01, {7'h0, tx_active});
    @(posedge clk) tx_shifting <= 1'b0;
    put(4'h0, 8'h60, 5'h00);
    repeat (20) @(posedge clk);
    #1 chk("active", 8'h00, {7'h0, tx_active});
    chk("hold", 8'h00, {7'h0, tx_hold_off});
    @(posedge clk) loopback <= 1'b1;
    #1 chk("rx", 8'h01, {7'h0, rx_active});
    @(posedge clk) resetn <= 1'b0;
    repeat (2) @(posedge clk);
    resetn <= 1'b1;
    {tx_en, rx_en, db, err} = 7'h00;
    step(4'h0, 8'h00, 5'h00);
    close_out;
  end
endmodule // ucd_decoder_bench

bind ucd_decoder ucd_checker i_chk (.*);
